// ==== logic/icc_map.svh ====
// Register offsets, buffer sizes, reset values and timing constants
// Assumes a 125 MHz switch clock and a byte-addressed 32-bit register port
`ifndef ICC_MAP_SVH
`define ICC_MAP_SVH
`define ICC_A_CTRL      8'h00
`define ICC_A_PFC_EN    8'h04
`define ICC_A_PTIME     8'h08
`define ICC_A_ING_KB    8'h0C
`define ICC_A_EGR_KB    8'h10
`define ICC_A_PROF_SEL  8'h18
`define ICC_A_PROF_DAT  8'h1C
`define ICC_A_STATUS    8'h20
`define ICC_A_ING_DEP   8'h24
`define ICC_A_DROPS     8'h28
`define ICC_A_COS       8'h40
`define ICC_A_HWM       8'h60
`define ICC_A_LWM       8'h80
`define ICC_A_MCL       8'hA0
`define ICC_A_GRP_MASK  8'hE0
`define ICC_PROF_LAST   9'h180
`define ICC_PCT_FULL    32'h00000064
`define ICC_BUF_1G      32'h00010000
`define ICC_BUF_10G     32'h00040000
`define ICC_BUF_40G     32'h00100000
`define ICC_BUF_100G    32'h00200000
`define ICC_KB_BYTES    32'h00000400
`define ICC_RST_LIMIT   16'hFFFF
`define ICC_RST_PTIME   16'hFFFF
`define ICC_CLK_NS      8
`define ICC_GBPS_1G     1
`define ICC_GBPS_10G    10
`define ICC_GBPS_40G    40
`define ICC_GBPS_100G   100
`define ICC_QUANTUM_BITS 512
`define ICC_WIN_NS      1000000000
`define ICC_LFSR_SEED   16'hACE1
`endif

// ==== logic/icc_pkg.sv ====
// Types shared by the ingress congestion control block
// Assumes the constants of icc_map.svh
package icc_pkg;
    typedef enum logic [1:0] {
        ICC_SPD_1G, ICC_SPD_10G, ICC_SPD_40G, ICC_SPD_100G
    } icc_speed_t;

    typedef struct packed {
        logic [6:0] prob;
        logic [6:0] max_pct;
        logic [6:0] min_pct;
    } icc_prof_t;

    typedef struct packed {
        logic [13:0] len;
        logic [2:0]  cos;
    } icc_pkt_t;

    typedef struct packed {
        logic [31:0]       rdata;
        logic              pfc_mode;
        logic              tx_en;
        logic              rx_en;
        logic              eff_tx;
        logic              eff_rx;
        logic [7:0]        pfc_tx;
        logic [7:0]        pfc_rx;
        logic [15:0]       ptime;
        logic [15:0]       ing_kb;
        logic [15:0]       egr_kb;
        logic [8:0]        prof_sel;
        logic [7:0][8:0]   cos_prof;
        logic [7:0]        cos_red;
        logic [7:0][23:0]  hwm;
        logic [7:0][23:0]  lwm;
        logic [7:0][15:0]  mc_lim;
        logic [7:0][15:0]  mc_cnt;
        logic [31:0]       win_cnt;
        logic [7:0][23:0]  depth;
        logic [23:0]       egr_depth;
        logic [7:0]        xoff;
        logic [7:0][15:0]  tmr;
        logic [7:0]        halt;
        logic [10:0]       bit_acc;
        logic [15:0]       lfsr;
        logic              dec_valid;
        logic              dec_drop;
        logic              egr_valid;
        logic              egr_drop;
        logic              mc_valid;
        logic              mc_pass;
        logic              pause_valid;
        logic [7:0]        pause_mask;
        logic [31:0]       drops;
    } icc_state_t;
endpackage : icc_pkg

// ==== logic/icc_top.sv ====
// Ingress congestion control: discard, queue limits, pause, multicast limits
// Assumes a MAC that halts only between frames and a register port master
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "icc_map.svh"

////////////////////////////////////////////////////////////////////////////
module icc_top #(
    parameter int unsigned MC_WIN_CYC = `ICC_WIN_NS / `ICC_CLK_NS
) (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic [7:0]               addr,
    input  wire logic [31:0]              wdata,
    input  wire logic                     we,
    input  wire logic                     re,
    output logic      [31:0]              rdata,
    input  wire icc_pkg::icc_speed_t      speed,
    input  wire logic                     pkt_valid,
    input  wire icc_pkg::icc_pkt_t        pkt,
    output logic                          dec_valid,
    output logic                          dec_drop,
    input  wire logic                     deq_valid,
    input  wire icc_pkg::icc_pkt_t        deq,
    input  wire logic                     egr_req,
    input  wire logic [13:0]              egr_len,
    output logic                          egr_valid,
    output logic                          egr_drop,
    input  wire logic                     egr_rel,
    input  wire logic [13:0]              egr_rel_len,
    input  wire logic                     rx_pause_valid,
    input  wire logic                     rx_pause_pfc,
    input  wire logic [7:0]               rx_pause_vec,
    input  wire logic [7:0][15:0]         rx_pause_time,
    output logic                          pause_valid,
    output logic                          pause_pfc,
    output logic      [7:0]               pause_mask,
    output logic      [15:0]              pause_time,
    output logic      [7:0]               tx_halt,
    input  wire logic                     an_done,
    input  wire logic                     lp_adv_rx,
    input  wire logic                     lp_adv_tx,
    output logic                          adv_rx,
    output logic                          adv_tx,
    input  wire logic                     mc_req,
    input  wire logic [2:0]               mc_tc,
    output logic                          mc_valid,
    output logic                          mc_pass
);

    ////////////////////////////////////////////////////////////////////////
    // State, profile memory and helpers
    icc_pkg::icc_state_t s;
    icc_pkg::icc_state_t n;
    logic [20:0]         prof_mem [0:384];
    icc_pkg::icc_prof_t  prof;
    logic [31:0]         buf_bytes;
    logic [31:0]         bpc;
    logic [31:0]         total;
    logic [31:0]         occ;
    logic                over_min;
    logic                over_max;
    logic                rnd_hit;
    logic                tail;
    logic                ing_over;
    logic                drop;
    logic [7:0]          xoff_n;
    logic [7:0][31:0]    lvl;
    logic                pause_ok;
    logic [23:0]         dep;
    logic [11:0]         acc_sum;
    logic                tick;
    logic                win_end;

    always_comb begin
        case (speed)
            icc_pkg::ICC_SPD_1G: begin
                buf_bytes = `ICC_BUF_1G;
                bpc       = 32'(`ICC_GBPS_1G * `ICC_CLK_NS);
            end
            icc_pkg::ICC_SPD_10G: begin
                buf_bytes = `ICC_BUF_10G;
                bpc       = 32'(`ICC_GBPS_10G * `ICC_CLK_NS);
            end
            icc_pkg::ICC_SPD_40G: begin
                buf_bytes = `ICC_BUF_40G;
                bpc       = 32'(`ICC_GBPS_40G * `ICC_CLK_NS);
            end
            default: begin
                buf_bytes = `ICC_BUF_100G;
                bpc       = 32'(`ICC_GBPS_100G * `ICC_CLK_NS);
            end
        endcase
    end

    always_comb begin
        total = 32'h0;
        for (int i = 0; i < 8; i++) begin
            total = total + {8'h0, s.depth[i]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Admission decision at enqueue
    assign prof     = icc_pkg::icc_prof_t'(prof_mem[s.cos_prof[pkt.cos]]);
    assign occ      = {8'h0, s.depth[pkt.cos]};
    // Compare occupancy*100 with pct*buffer to avoid a divider
    assign over_min = occ * `ICC_PCT_FULL
                      > {25'h0, prof.min_pct} * buf_bytes;
    assign over_max = occ * `ICC_PCT_FULL
                      > {25'h0, prof.max_pct} * buf_bytes;
    assign rnd_hit  = {16'h0, s.lfsr} * `ICC_PCT_FULL
                      < {9'h0, prof.prob, 16'h0};
    assign tail     = total + {18'h0, pkt.len} > buf_bytes;
    assign ing_over = total + {18'h0, pkt.len}
                      > {16'h0, s.ing_kb} * `ICC_KB_BYTES;
    assign drop     = tail || ing_over || (s.cos_red[pkt.cos]
                      && (over_max || (over_min && rnd_hit)));

    // Hysteresis level per priority, or whole port in plain mode
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lvl[i] = s.pfc_mode ? {8'h0, s.depth[i]} : total;
            if (lvl[i] > {8'h0, s.hwm[i]}) begin
                xoff_n[i] = 1'b1;
            end else if (lvl[i] < {8'h0, s.lwm[i]}) begin
                xoff_n[i] = 1'b0;
            end else begin
                xoff_n[i] = s.xoff[i];
            end
        end
    end

    // Received pause only honoured in the configured mode
    assign pause_ok = rx_pause_valid && (rx_pause_pfc == s.pfc_mode);
    assign acc_sum  = {1'b0, s.bit_acc} + bpc[11:0];
    assign tick     = acc_sum >= 12'(`ICC_QUANTUM_BITS);
    assign win_end  = s.win_cnt == MC_WIN_CYC - 1;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        n             = s;
        dep           = 24'h0;
        n.dec_valid   = pkt_valid;
        n.dec_drop    = pkt_valid && drop;
        n.egr_valid   = egr_req;
        n.egr_drop    = 1'b0;
        n.mc_valid    = mc_req;
        n.mc_pass     = 1'b0;
        n.pause_valid = 1'b0;
        n.pause_mask  = 8'h00;
        n.lfsr = {s.lfsr[14:0],
                  s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};
        n.rdata = 32'h0;
        if (re) begin
            if (addr == `ICC_A_CTRL) begin
                n.rdata = {27'h0, s.eff_rx, s.eff_tx, s.rx_en, s.tx_en,
                           s.pfc_mode};
            end else if (addr == `ICC_A_PFC_EN) begin
                n.rdata = {16'h0, s.pfc_rx, s.pfc_tx};
            end else if (addr == `ICC_A_PTIME) begin
                n.rdata = {16'h0, s.ptime};
            end else if (addr == `ICC_A_ING_KB) begin
                n.rdata = {16'h0, s.ing_kb};
            end else if (addr == `ICC_A_EGR_KB) begin
                n.rdata = {16'h0, s.egr_kb};
            end else if (addr == `ICC_A_PROF_SEL) begin
                n.rdata = {23'h0, s.prof_sel};
            end else if (addr == `ICC_A_PROF_DAT) begin
                n.rdata = {11'h0, prof_mem[s.prof_sel]};
            end else if (addr == `ICC_A_STATUS) begin
                n.rdata = {16'h0, s.halt, s.xoff};
            end else if (addr == `ICC_A_ING_DEP) begin
                n.rdata = total;
            end else if (addr == `ICC_A_DROPS) begin
                n.rdata = s.drops;
            end else if ((addr & `ICC_A_GRP_MASK) == `ICC_A_COS) begin
                n.rdata = {22'h0, s.cos_red[addr[4:2]],
                           s.cos_prof[addr[4:2]]};
            end else if ((addr & `ICC_A_GRP_MASK) == `ICC_A_HWM) begin
                n.rdata = {8'h0, s.hwm[addr[4:2]]};
            end else if ((addr & `ICC_A_GRP_MASK) == `ICC_A_LWM) begin
                n.rdata = {8'h0, s.lwm[addr[4:2]]};
            end else if ((addr & `ICC_A_GRP_MASK) == `ICC_A_MCL) begin
                n.rdata = {16'h0, s.mc_lim[addr[4:2]]};
            end
        end
        if (we) begin
            if (addr == `ICC_A_CTRL) begin
                n.pfc_mode = wdata[0];
                n.tx_en    = wdata[1];
                n.rx_en    = wdata[2];
                n.eff_tx   = wdata[1];
                n.eff_rx   = wdata[2];
            end else if (addr == `ICC_A_PFC_EN) begin
                n.pfc_tx = wdata[7:0];
                n.pfc_rx = wdata[15:8];
            end else if (addr == `ICC_A_PTIME) begin
                n.ptime = wdata[15:0];
            end else if (addr == `ICC_A_ING_KB) begin
                n.ing_kb = wdata[15:0];
            end else if (addr == `ICC_A_EGR_KB) begin
                n.egr_kb = wdata[15:0];
            end else if (addr == `ICC_A_PROF_SEL) begin
                if (wdata[8:0] <= `ICC_PROF_LAST) begin
                    n.prof_sel = wdata[8:0];
                end
            end else if ((addr & `ICC_A_GRP_MASK) == `ICC_A_COS) begin
                if (wdata[8:0] <= `ICC_PROF_LAST) begin
                    n.cos_prof[addr[4:2]] = wdata[8:0];
                end
                n.cos_red[addr[4:2]] = wdata[9];
            end else if ((addr & `ICC_A_GRP_MASK) == `ICC_A_HWM) begin
                n.hwm[addr[4:2]] = wdata[23:0];
            end else if ((addr & `ICC_A_GRP_MASK) == `ICC_A_LWM) begin
                n.lwm[addr[4:2]] = wdata[23:0];
            end else if ((addr & `ICC_A_GRP_MASK) == `ICC_A_MCL) begin
                n.mc_lim[addr[4:2]] = wdata[15:0];
            end
        end
        // Pause resolution after autonegotiation
        if (an_done && !(we && addr == `ICC_A_CTRL)) begin
            if (speed == icc_pkg::ICC_SPD_1G) begin
                n.eff_tx = s.tx_en && lp_adv_rx
                           && (lp_adv_tx || s.rx_en);
                n.eff_rx = s.rx_en && (lp_adv_tx || lp_adv_rx)
                           && (s.tx_en || lp_adv_rx);
            end else begin
                n.eff_tx = s.tx_en;
                n.eff_rx = s.rx_en;
            end
        end
        // Queue depth bookkeeping
        for (int i = 0; i < 8; i++) begin
            dep = s.depth[i];
            if (pkt_valid && !drop && pkt.cos == 3'(i)) begin
                dep = dep + {10'h0, pkt.len};
            end
            if (deq_valid && deq.cos == 3'(i)) begin
                dep = (dep > {10'h0, deq.len})
                      ? dep - {10'h0, deq.len} : 24'h0;
            end
            n.depth[i] = dep;
        end
        if (pkt_valid && drop) begin
            n.drops = s.drops + 32'h1;
        end
        // Egress admission against its own limit
        dep = s.egr_depth;
        if (egr_req) begin
            if ({8'h0, s.egr_depth} + {18'h0, egr_len}
                > {16'h0, s.egr_kb} * `ICC_KB_BYTES) begin
                n.egr_drop = 1'b1;
            end else begin
                dep = dep + {10'h0, egr_len};
            end
        end
        if (egr_rel) begin
            dep = (dep > {10'h0, egr_rel_len})
                  ? dep - {10'h0, egr_rel_len} : 24'h0;
        end
        n.egr_depth = dep;
        // Pause generation with hysteresis
        n.xoff = xoff_n;
        if (s.pfc_mode) begin
            for (int i = 0; i < 8; i++) begin
                n.pause_mask[i] = s.pfc_tx[i] && xoff_n[i]
                    && (!s.xoff[i] || (pkt_valid
                        && pkt.cos == 3'(i)));
            end
        end else if (s.eff_tx && xoff_n[0]
                     && (!s.xoff[0] || pkt_valid)) begin
            n.pause_mask = 8'hFF;
        end
        n.pause_valid = |n.pause_mask;
        // Received pause timers in 512-bit quanta
        n.bit_acc = tick ? 11'(acc_sum - 12'(`ICC_QUANTUM_BITS))
                         : acc_sum[10:0];
        for (int i = 0; i < 8; i++) begin
            if (tick && s.tmr[i] != 16'h0) begin
                n.tmr[i] = s.tmr[i] - 16'h1;
            end
            if (pause_ok && !s.pfc_mode && s.eff_rx) begin
                n.tmr[i] = rx_pause_time[0];
            end else if (pause_ok && s.pfc_mode && rx_pause_vec[i]
                         && s.pfc_rx[i]) begin
                n.tmr[i] = rx_pause_time[i];
            end
            n.halt[i] = n.tmr[i] != 16'h0;
        end
        // Multicast replication rate limit per traffic class
        n.win_cnt = win_end ? 32'h0 : s.win_cnt + 32'h1;
        for (int i = 0; i < 8; i++) begin
            if (win_end) begin
                n.mc_cnt[i] = 16'h0;
            end
        end
        if (mc_req && s.mc_cnt[mc_tc] < s.mc_lim[mc_tc]) begin
            n.mc_pass = 1'b1;
            if (!win_end) begin
                n.mc_cnt[mc_tc] = s.mc_cnt[mc_tc] + 16'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s        <= '0;
            s.ptime  <= `ICC_RST_PTIME;
            s.ing_kb <= `ICC_RST_LIMIT;
            s.egr_kb <= `ICC_RST_LIMIT;
            s.mc_lim <= {8{`ICC_RST_LIMIT}};
            s.lfsr   <= `ICC_LFSR_SEED;
        end else begin
            s <= n;
        end
    end

    always_ff @(posedge clk) begin
        if (we && addr == `ICC_A_PROF_DAT) begin
            prof_mem[s.prof_sel] <= wdata[20:0];
        end
    end

    assign rdata       = s.rdata;
    assign dec_valid   = s.dec_valid;
    assign dec_drop    = s.dec_drop;
    assign egr_valid   = s.egr_valid;
    assign egr_drop    = s.egr_drop;
    assign pause_valid = s.pause_valid;
    assign pause_pfc   = s.pfc_mode;
    assign pause_mask  = s.pause_mask;
    assign pause_time  = s.ptime;
    assign tx_halt     = s.halt;
    assign adv_rx      = s.rx_en;
    assign adv_tx      = s.tx_en;
    assign mc_valid    = s.mc_valid;
    assign mc_pass     = s.mc_pass;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    max_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
        pkt_valid && s.cos_red[pkt.cos] && over_max |=> dec_valid && dec_drop)
        else $error("packet above max threshold not dropped");
    ing_limit_a: assert property (@(posedge clk) disable iff (sys_rst)
        pkt_valid && ing_over |=> dec_drop && s.drops == $past(s.drops) + 1)
        else $error("ingress limit not enforced");
    tail_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
        pkt_valid && !tail && !ing_over && !s.cos_red[pkt.cos]
        |=> dec_valid && !dec_drop)
        else $error("frame dropped with buffer room left");
    pause_on_a: assert property (@(posedge clk) disable iff (sys_rst)
        !s.pfc_mode && s.eff_tx && !s.xoff[0] && total > {8'h0, s.hwm[0]}
        |=> pause_valid && pause_mask == 8'hFF && s.xoff[0])
        else $error("no pause on high-water crossing");
    pause_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        s.xoff[0] && lvl[0] < {8'h0, s.lwm[0]} && !s.pfc_mode
        && lvl[0] <= {8'h0, s.hwm[0]} |=> !s.xoff[0] && !pause_valid)
        else $error("pause continued below low-water mark");
    rx_halt_a: assert property (@(posedge clk) disable iff (sys_rst)
        pause_ok && !s.pfc_mode && s.eff_rx && rx_pause_time[0] > 16'h1
        |=> tx_halt == 8'hFF [*2])
        else $error("received pause did not halt output");
    mc_limit_a: assert property (@(posedge clk) disable iff (sys_rst)
        mc_req && !win_end && s.mc_cnt[mc_tc] >= s.mc_lim[mc_tc]
        |=> mc_valid && !mc_pass)
        else $error("multicast limit exceeded");
    ptime_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
        re && addr == `ICC_A_PTIME && !we |=> rdata == {16'h0, pause_time})
        else $error("pause time readback mismatch");

endmodule : icc_top
`default_nettype wire

// ==== test/icc_peer.sv ====
// Link partner model: sends pause frames, advertises pause ability
// Assumes the bench calls send from its main sequence
`timescale 1ns/1ps
`default_nettype none
module icc_peer (
    input  wire logic             clk,
    output logic                  rx_pause_valid,
    output logic                  rx_pause_pfc,
    output logic      [7:0]       rx_pause_vec,
    output logic      [7:0][15:0] rx_pause_time,
    output logic                  lp_adv_rx,
    output logic                  lp_adv_tx
);
    initial begin
        {rx_pause_valid, rx_pause_pfc, rx_pause_vec} = '0;
        {lp_adv_rx, lp_adv_tx} = 2'b11;
        rx_pause_time = '1;
    end
    // One frame, count in quanta, same mode as the device
    task automatic send(input logic pfc, input logic [15:0] t);
        @(posedge clk);
        rx_pause_valid <= 1'b1;
        rx_pause_pfc <= pfc;
        rx_pause_vec <= {8{pfc}};
        rx_pause_time <= {8{t}};
        @(posedge clk);
        rx_pause_valid <= 1'b0;
        rx_pause_time <= ~{8{t}};
    endtask : send
    // Pause ability offered in the next negotiation
    task automatic advertise(input logic r, input logic t);
        @(posedge clk);
        lp_adv_rx <= r;
        lp_adv_tx <= t;
    endtask : advertise
endmodule : icc_peer
`default_nettype wire

// ==== test/ingress_congestion_control_test.sv ====
// Bench: registers, discard, queue limit, pause out and in, multicast
// Assumes icc_top at 1G with the map of icc_map.svh
`timescale 1ns/1ps
`default_nettype none
`include "icc_map.svh"
module ingress_congestion_control_test;
    logic clk = 0, sys_rst = 1, we = 0, re = 0, pkt_valid = 0, mc_req = 0;
    logic deq_valid = 0, egr_req = 0, an_done = 0, egr_valid, egr_drop;
    logic [13:0] egr_len = '0;
    icc_pkg::icc_pkt_t deq = '0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0;
    logic [2:0] mc_tc = '0;
    icc_pkg::icc_pkt_t pkt = '0;
    logic [31:0] rdata;
    logic [7:0] pause_mask, tx_halt, rx_pause_vec;
    logic [7:0][15:0] rx_pause_time;
    logic [15:0] pause_time;
    logic dec_valid, dec_drop, pause_valid, pause_pfc, adv_rx, adv_tx;
    logic mc_valid, mc_pass, rx_pause_valid, rx_pause_pfc, lp_adv_rx, lp_adv_tx;
    int fail_count = 0, comparisons = 0, n;
    always #4 clk = ~clk;
    icc_peer icc_peer_inst (.clk, .rx_pause_valid, .rx_pause_pfc,
        .rx_pause_vec, .rx_pause_time, .lp_adv_rx, .lp_adv_tx);
    icc_top #(.MC_WIN_CYC(20000)) icc_top_inst (.clk, .sys_rst, .addr,
        .wdata, .we, .re, .rdata, .speed(icc_pkg::ICC_SPD_1G), .pkt_valid,
        .pkt, .dec_valid, .dec_drop, .deq_valid, .deq,
        .egr_req, .egr_len, .egr_valid, .egr_drop,
        .egr_rel(1'b0), .egr_rel_len('0), .rx_pause_valid, .rx_pause_pfc,
        .rx_pause_vec, .rx_pause_time, .pause_valid, .pause_pfc, .pause_mask,
        .pause_time, .tx_halt, .an_done, .lp_adv_rx, .lp_adv_tx,
        .adv_rx, .adv_tx, .mc_req, .mc_tc, .mc_valid, .mc_pass);
    task automatic give_verdict;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic chk(string s, logic [31:0] e, logic [31:0] v);
        comparisons++;
        if (v !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", s, e, v);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        {we, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        we <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        {re, addr} <= {1'b1, a};
        @(posedge clk);
        re <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask : rd
    task automatic pk(logic [13:0] l, logic [2:0] c, logic e);
        @(posedge clk);
        {pkt_valid, pkt} <= {1'b1, l, c};
        @(posedge clk);
        pkt_valid <= 1'b0;
        #1 chk("dec_valid", 1, dec_valid);
        chk("dec_drop", e, dec_drop);
    endtask : pk
    task automatic mc(logic [2:0] c, logic e);
        @(posedge clk);
        {mc_req, mc_tc} <= {1'b1, c};
        @(posedge clk);
        mc_req <= 1'b0;
        #1 chk("mc_valid", 1, mc_valid);
        chk("mc_pass", e, mc_pass);
    endtask : mc
    task automatic eg(logic [13:0] l, logic e);
        @(posedge clk);
        {egr_req, egr_len} <= {1'b1, l};
        @(posedge clk);
        egr_req <= 1'b0;
        #1 chk("egr_valid", 1, egr_valid);
        chk("egr_drop", e, egr_drop);
    endtask : eg
    task automatic dq(logic [13:0] l, logic [2:0] c);
        @(posedge clk);
        {deq_valid, deq} <= {1'b1, l, c};
        @(posedge clk);
        deq_valid <= 1'b0;
    endtask : dq
    task automatic neg(logic r, logic t, logic [31:0] e);
        icc_peer_inst.advertise(r, t);
        @(posedge clk);
        an_done <= 1'b1;
        @(posedge clk);
        an_done <= 1'b0;
        rd(`ICC_A_CTRL, e);
    endtask : neg
    task automatic wait_pause(logic [7:0] m);
        for (n = 0; n < 8 && pause_valid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk("pause_valid", 1, pause_valid);
        chk("pause_mask", {24'h0, m}, pause_mask);
        if (n == 8) give_verdict;
    endtask : wait_pause
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`ICC_A_PTIME, 32'hFFFF);
        rd(8'h14, 32'h0);
        wr(`ICC_A_HWM, 32'h64);
        wr(`ICC_A_LWM, 32'h32);
        wr(`ICC_A_CTRL, 32'h6);
        rd(`ICC_A_CTRL, 32'h1E);
        chk("adv_rx_tx", 32'h3, {adv_rx, adv_tx});
        chk("pause_time", 32'hFFFF, pause_time);
        chk("pause_pfc", 0, pause_pfc);
        wr(`ICC_A_CTRL, 32'h2);
        neg(1'b1, 1'b1, 32'h0A);
        wr(`ICC_A_CTRL, 32'h6);
        neg(1'b0, 1'b1, 32'h16);
        neg(1'b0, 1'b0, 32'h06);
        neg(1'b1, 1'b1, 32'h1E);
        pk(14'h32, 3'h0, 0);
        pk(14'h3C, 3'h0, 0);
        wait_pause(8'hFF);
        pk(14'h0A, 3'h0, 0);
        wait_pause(8'hFF);
        wr(`ICC_A_PROF_SEL, 32'h180);
        wr(`ICC_A_PROF_DAT, 32'h0);
        wr(`ICC_A_COS + 8'h0C, 32'h380);
        pk(14'h0A, 3'h3, 0);
        pk(14'h0A, 3'h3, 1);
        wr(`ICC_A_PROF_DAT, 32'h3200);
        pk(14'h0A, 3'h3, 0);
        wr(`ICC_A_PROF_DAT, 32'h193200);
        rd(`ICC_A_PROF_DAT, 32'h193200);
        pk(14'h0A, 3'h3, 1);
        wr(`ICC_A_ING_KB, 32'h1);
        pk(14'h3E8, 3'h0, 1);
        pk(14'h320, 3'h0, 0);
        wr(`ICC_A_EGR_KB, 32'h1);
        eg(14'h3E8, 0);
        eg(14'h064, 1);
        dq(14'h3FFF, 3'h0);
        dq(14'h3FFF, 3'h3);
        pk(14'h0A, 3'h0, 0);
        chk("pause_valid", 0, pause_valid);
        wr(`ICC_A_MCL + 8'h08, 32'h2);
        mc(3'h2, 1);
        mc(3'h2, 1);
        mc(3'h2, 0);
        mc(3'h3, 1);
        icc_peer_inst.send(1'b0, 16'h3);
        #1 chk("tx_halt", 32'hFF, tx_halt);
        for (n = 0; n < 300 && tx_halt !== 8'h0; n++) begin
            @(posedge clk);
            #1;
        end
        chk("halt_cycles", 1, n > 128 && n < 200);
        wr(`ICC_A_PFC_EN, 32'h0508);
        wr(`ICC_A_CTRL, 32'h7);
        rd(`ICC_A_CTRL, 32'h1F);
        chk("pause_pfc", 1, pause_pfc);
        pk(14'h0A, 3'h3, 0);
        wait_pause(8'h08);
        icc_peer_inst.send(1'b1, 16'h2);
        #1 chk("tx_halt", 32'h05, tx_halt);
        give_verdict;
    end
endmodule : ingress_congestion_control_test
`default_nettype wire
